// ===== rtl/periph_trigger_routing_regs.svh
// Constants for the peripheral trigger routing block
`ifndef PERIPH_TRIGGER_ROUTING_REGS_SVH
`define PERIPH_TRIGGER_ROUTING_REGS_SVH

`define PTR_NUM_CH 8
`define PTR_SYNC_MASTER_A 0
`define PTR_SYNC_MASTER_B 4
`define PTR_CAP_TRIG_SRC_A 6
`define PTR_CAP_TRIG_SRC_B 7
`define PTR_CAP_GROUP_A_LAST 3
`define PTR_CAP_GROUP_B_LAST 5
`define PTR_CAP_PRESENT 8'h8b
`define PTR_SIO0_CLK_SRC 0
`define PTR_SIO1_CLK_SRC 1
`define PTR_ADC_NORMAL_SRC 0
`define PTR_ADC_TOP_SRC 1

`endif

// ===== rtl/periph_trigger_routing_pkg.sv
// Types shared by the peripheral trigger routing block
package periph_trigger_routing_pkg;

    // Per-channel events coming from the timer channels
    typedef struct packed {
        logic [7:0] timerOut;
        logic [7:0] compareMatch;
        logic [7:0] firstCapture;
        logic [7:0] secondCapture;
        logic [7:0] runRequest;
    } timer_events_t;

    // Signals delivered to converter and serial channels
    typedef struct packed {
        logic normalStart;
        logic topStart;
        logic [1:0] serialClock;
    } periph_triggers_t;

endpackage : periph_trigger_routing_pkg

// ===== rtl/periph_trigger_routing.sv
// Routing of timer events to timer, serial and converter peripherals
//------------------------------------------------------------------
//------------------------------------------------------------------
`timescale 1ns/1ps
`include "periph_trigger_routing_regs.svh"

module periph_trigger_routing
    import periph_trigger_routing_pkg::*;
#(
    parameter int NumCh = `PTR_NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Timer side
    input wire timer_events_t timerEv,
    input wire logic [NumCh-1:0] timerCapturePin,
    // Routed outputs
    output logic [NumCh-1:0] syncStart,
    output logic [NumCh-1:0] captureTrigger,
    output logic [NumCh-1:0] captureIrq,
    output logic [NumCh-1:0] capturePinLevel,
    output periph_triggers_t periphTrig
);

    //------------------------------------------------------------------
    // Routing functions
    //------------------------------------------------------------------
    // Master of a channel's synchronous-start group
    function automatic int syncMaster(input int ch);
        syncMaster = (ch < `PTR_SYNC_MASTER_B) ? `PTR_SYNC_MASTER_A : `PTR_SYNC_MASTER_B;
    endfunction : syncMaster

    // Source of a channel's capture trigger; -1 when the channel has none
    function automatic int capSource(input int ch);
        if (ch <= `PTR_CAP_GROUP_A_LAST) begin
            capSource = `PTR_CAP_TRIG_SRC_A;
        end else if (ch <= `PTR_CAP_GROUP_B_LAST) begin
            capSource = `PTR_CAP_TRIG_SRC_B;
        end else begin
            capSource = -1;
        end
    endfunction : capSource

    //------------------------------------------------------------------
    // Output edge detection for capture triggers
    //------------------------------------------------------------------
    logic [NumCh-1:0] outPrev_r, outPrev_nxt;
    logic [NumCh-1:0] syncStart_r, syncStart_nxt;
    logic [NumCh-1:0] capTrig_r, capTrig_nxt;
    logic [NumCh-1:0] capIrq_r, capIrq_nxt;
    logic [NumCh-1:0] pinLvl_r, pinLvl_nxt;
    periph_triggers_t trig_r, trig_nxt;
    logic [NumCh-1:0] outRise;

    assign outRise = timerEv.timerOut[NumCh-1:0] & ~outPrev_r;

    //------------------------------------------------------------------
    // Per-channel routing
    //------------------------------------------------------------------
    logic [NumCh-1:0] capPresent;
    assign capPresent = NumCh'(`PTR_CAP_PRESENT);

    genvar g;
    generate
        for (g = 0; g < NumCh; g++) begin : gCh
            // Channels without a source keep a legal index, so no select runs out of range
            localparam int CapSrc = capSource(g);
            localparam int CapIdx = (CapSrc >= 0) ? CapSrc : 0;
            always_comb begin
                // Slaves follow the master's run request one cycle later, starting in the same cycle as the master
                syncStart_nxt[g] = timerEv.runRequest[syncMaster(g)];
                if (CapSrc >= 0) begin
                    capTrig_nxt[g] = outRise[CapIdx];
                end else begin
                    capTrig_nxt[g] = 1'b0;
                end
                // One source for both captures; pin is latched for the handler
                capIrq_nxt[g] = capPresent[g] & (timerEv.firstCapture[g] | timerEv.secondCapture[g]);
                pinLvl_nxt[g] = capPresent[g] & timerCapturePin[g];
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // Converter and serial routing
    //------------------------------------------------------------------
    always_comb begin
        trig_nxt.normalStart = timerEv.compareMatch[`PTR_ADC_NORMAL_SRC];
        trig_nxt.topStart = timerEv.compareMatch[`PTR_ADC_TOP_SRC];
        // Clock is passed as a level; no handshake input exists
        trig_nxt.serialClock = {timerEv.timerOut[`PTR_SIO1_CLK_SRC],
                                timerEv.timerOut[`PTR_SIO0_CLK_SRC]};
        outPrev_nxt = timerEv.timerOut[NumCh-1:0];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outPrev_r <= '0;
            syncStart_r <= '0;
            capTrig_r <= '0;
            capIrq_r <= '0;
            pinLvl_r <= '0;
            trig_r <= '0;
        end else begin
            outPrev_r <= outPrev_nxt;
            syncStart_r <= syncStart_nxt;
            capTrig_r <= capTrig_nxt;
            capIrq_r <= capIrq_nxt;
            pinLvl_r <= pinLvl_nxt;
            trig_r <= trig_nxt;
        end
    end

    assign syncStart = syncStart_r;
    assign captureTrigger = capTrig_r;
    assign captureIrq = capIrq_r;
    assign capturePinLevel = pinLvl_r;
    assign periphTrig = trig_r;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_sync_group_start: assert property (syncStart[1] == syncStart[0] && syncStart[3] == syncStart[2]
        && syncStart[5] == syncStart[4] && syncStart[7] == syncStart[6])
        else $error("sync group slaves disagree with master");
    a_sync_follow_master: assert property (timerEv.runRequest[4] |=> syncStart[7])
        else $error("slave 7 did not follow master 4");
    a_cap_trig_low: assert property ($rose(timerEv.timerOut[6]) |=> captureTrigger[0] && captureTrigger[3])
        else $error("timer 6 output did not trigger low group");
    a_cap_trig_high: assert property ($rose(timerEv.timerOut[7]) |=> captureTrigger[4] && captureTrigger[5])
        else $error("timer 7 output did not trigger high group");
    a_cap_trig_pulse: assert property (captureTrigger[0] |=> !captureTrigger[0])
        else $error("capture trigger longer than one cycle");
    a_cap_irq_merge: assert property (timerEv.secondCapture[3] |=> captureIrq[3])
        else $error("second capture not merged on channel 3");
    a_no_cap_chan: assert property (!captureIrq[2] && !captureIrq[4] && !captureIrq[6])
        else $error("capture interrupt on channel without input");
    a_pin_level: assert property (captureIrq[0] |-> capturePinLevel[0] == $past(timerCapturePin[0]))
        else $error("pin level not latched with interrupt");
    a_serial_clk: assert property ($past(rstn) |-> periphTrig.serialClock[1] == $past(timerEv.timerOut[1]))
        else $error("serial 1 clock not from timer 1");
    a_adc_normal: assert property (timerEv.compareMatch[0] |=> periphTrig.normalStart)
        else $error("normal conversion not started");
    a_adc_top: assert property (timerEv.compareMatch[1] |=> periphTrig.topStart)
        else $error("top-priority conversion not started");

    //------------------------------------------------------------------
    // Synchronous start checks
    //------------------------------------------------------------------
    // Slaves copy only their own master, never the other group's request
    a_sync_group_a: assert property (
        timerEv.runRequest[`PTR_SYNC_MASTER_A] |=> syncStart[3:0] == 4'hf)
        else $error("group A slaves did not start with master 0");
    a_sync_idle_a: assert property (
        !timerEv.runRequest[`PTR_SYNC_MASTER_A] |=> syncStart[3:0] == 4'h0)
        else $error("group A started without master 0");
    a_sync_idle_b: assert property (
        !timerEv.runRequest[`PTR_SYNC_MASTER_B] |=> syncStart[7:4] == 4'h0)
        else $error("group B started without master 4");

    //------------------------------------------------------------------
    // Capture checks
    //------------------------------------------------------------------
    // A pulse must trace back to a high source output on the previous edge
    a_cap_cause_a: assert property (
        captureTrigger[0] |-> $past(timerEv.timerOut[`PTR_CAP_TRIG_SRC_A]))
        else $error("group A capture trigger without source output");
    a_cap_cause_b: assert property (
        captureTrigger[4] |-> $past(timerEv.timerOut[`PTR_CAP_TRIG_SRC_B]))
        else $error("group B capture trigger without source output");
    a_cap_trig_unused: assert property (
        captureTrigger[7:6] == 2'h0)
        else $error("capture trigger on channel without source");
    a_cap_pulse_b: assert property (
        captureTrigger[4] |=> !captureTrigger[4])
        else $error("group B capture trigger longer than one cycle");
    a_irq_first_merge: assert property (
        timerEv.firstCapture[7] |=> captureIrq[7])
        else $error("first capture not merged on channel 7");
    a_irq_cause: assert property (
        captureIrq[1] |-> $past(timerEv.firstCapture[1]) || $past(timerEv.secondCapture[1]))
        else $error("capture interrupt on channel 1 without event");
    a_pin_level_ch7: assert property (
        captureIrq[7] |-> capturePinLevel[7] == $past(timerCapturePin[7]))
        else $error("pin level of channel 7 not latched with interrupt");
    a_pin_mask: assert property (
        capturePinLevel[6:4] == 3'h0 && !capturePinLevel[2])
        else $error("pin level reported on channel without input");

    //------------------------------------------------------------------
    // Converter and serial checks
    //------------------------------------------------------------------
    a_serial_clk0: assert property (
        $past(rstn) |-> periphTrig.serialClock[0] == $past(timerEv.timerOut[`PTR_SIO0_CLK_SRC]))
        else $error("serial 0 clock not from timer 0");
    a_adc_normal_cause: assert property (
        periphTrig.normalStart |-> $past(timerEv.compareMatch[`PTR_ADC_NORMAL_SRC]))
        else $error("normal conversion started without match");
    a_adc_top_cause: assert property (
        periphTrig.topStart |-> $past(timerEv.compareMatch[`PTR_ADC_TOP_SRC]))
        else $error("top-priority conversion started without match");

    c_group_b_start: cover property (timerEv.runRequest[4] ##1 syncStart[5]);
    c_cap_trig: cover property ($rose(timerEv.timerOut[6]) ##1 captureTrigger[1]);
    c_cap_second: cover property (timerEv.secondCapture[7] && !timerCapturePin[7]);
    c_adc_both: cover property (periphTrig.normalStart && periphTrig.topStart);
    c_cap_first_high: cover property (captureIrq[0] && capturePinLevel[0]);

endmodule : periph_trigger_routing

// ===== sim/timer_bank_model.sv
// Behavioural bank of timer channels feeding the routing block
`timescale 1ns/1ps

module timer_bank_model
    import periph_trigger_routing_pkg::*;
(
    // Clock
    input wire logic clk,
    // Timer events and capture pins
    output timer_events_t timerEv,
    output logic [7:0] timerCapturePin
);
    initial begin
        timerEv = '0;
        timerCapturePin = 8'h00;
    end

    // Pins hold until the next drive, so each level outlasts the service time
    task automatic drive(input logic [7:0] outs, match, cap1, cap2, run, pins);
        @(negedge clk);
        timerEv = '{outs, match, cap1, cap2, run};
        timerCapturePin = pins;
    endtask : drive
endmodule : timer_bank_model

// ===== sim/periph_trigger_routing_tb_top.sv
// Self-checking testbench for the peripheral trigger routing block
`timescale 1ns/1ps

module periph_trigger_routing_tb_top;
    import periph_trigger_routing_pkg::*;
    logic clk;
    logic rstn;
    timer_events_t timerEv;
    logic [7:0] timerCapturePin, syncStart, captureTrigger, captureIrq, capturePinLevel;
    periph_triggers_t periphTrig;
    int nMismatch = 0;
    int numChecks = 0;

    timer_bank_model i_timer_bank_model (.clk(clk), .timerEv(timerEv), .timerCapturePin(timerCapturePin));
    periph_trigger_routing i_periph_trigger_routing (.clk(clk), .rstn(rstn), .timerEv(timerEv),
        .timerCapturePin(timerCapturePin), .syncStart(syncStart), .captureTrigger(captureTrigger),
        .captureIrq(captureIrq), .capturePinLevel(capturePinLevel), .periphTrig(periphTrig));

    //------------------------------------------------------------
    // Shared helpers
    //------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One cycle of latency: outputs are judged at the following falling edge
    task automatic apply(input logic [7:0] outs, match, cap1, cap2, run, pins);
        i_timer_bank_model.drive(outs, match, cap1, cap2, run, pins);
        @(negedge clk);
    endtask : apply

    task automatic complete_run;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic sync_groups;
        logic [7:0] runTab [4] = '{8'hee, 8'h01, 8'h10, 8'h11};
        logic [7:0] expTab [4] = '{8'h00, 8'h0f, 8'hf0, 8'hff};
        for (int i = 0; i < 4; i++) begin
            apply(8'h00, 8'h00, 8'h00, 8'h00, runTab[i], 8'h00);
            chk(syncStart, expTab[i]);
        end
    endtask : sync_groups

    task automatic capture_triggers;
        apply(8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        chk(captureTrigger, 8'h0f);
        @(negedge clk);
        chk(captureTrigger, 8'h00);
        apply(8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        chk(captureTrigger, 8'h30);
        @(negedge clk);
        chk(captureTrigger, 8'h00);
    endtask : capture_triggers

    task automatic capture_irqs;
        apply(8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff);
        chk(captureIrq, 8'h8b);
        chk(capturePinLevel, 8'h8b);
        apply(8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00);
        chk(captureIrq, 8'h8b);
        chk(capturePinLevel, 8'h00);
        apply(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        chk(captureIrq, 8'h00);
    endtask : capture_irqs

    task automatic periph_signals;
        apply(8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
        chk({4'h0, periphTrig}, 8'h09);
        apply(8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00);
        chk({4'h0, periphTrig}, 8'h06);
        apply(8'hfc, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h00);
        chk({4'h0, periphTrig}, 8'h00);
    endtask : periph_signals

    // Edge history clears in reset, so an output held high across release fires once
    task automatic reset_release;
        rstn = 1'b0;
        apply(8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        chk(captureTrigger, 8'h00);
        rstn = 1'b1;
        @(negedge clk);
        chk(captureTrigger, 8'h30);
        @(negedge clk);
        chk(captureTrigger, 8'h00);
    endtask : reset_release

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #100000;
        nMismatch++;
        complete_run();
    end

    initial begin
        rstn = 1'b0;
        apply(8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff);
        chk(syncStart | captureTrigger | captureIrq | capturePinLevel, 8'h00);
        apply(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        sync_groups();
        capture_triggers();
        capture_irqs();
        periph_signals();
        reset_release();
        complete_run();
    end
endmodule : periph_trigger_routing_tb_top
